// *** include/bcb_pkg.sv ***
// package of constants, types and a decode function for the bus channel buffer
`default_nettype none
package bcb_pkg;

	// ---------------------------------------------------------------
	// structure
	// ---------------------------------------------------------------
	localparam int BCB_NCH = 5;
	localparam int BCB_DW = 32;
	localparam int BCB_QDEPTH = 16;
	localparam int BCB_PTR_W = 4;
	localparam int BCB_LVL_W = 5;
	localparam int BCB_AXI_AW = 8;

	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] BCB_OFS_LINK_MODE = 8'h00;
	localparam logic [7:0] BCB_OFS_ARG_COUNT = 8'h04;
	localparam logic [7:0] BCB_OFS_ARG0 = 8'h08;
	localparam logic [7:0] BCB_OFS_ARG4 = 8'h18;
	localparam logic [7:0] BCB_OFS_OCCUPANCY = 8'h1C;
	localparam logic [7:0] BCB_OFS_EFF_DEPTH = 8'h20;

	// ---------------------------------------------------------------
	// argument word fields and codes
	// ---------------------------------------------------------------
	localparam int BCB_ARG_DEPTH_LSB = 0;
	localparam int BCB_ARG_VALID_BYPASS_BIT = 8;
	localparam int BCB_ARG_READY_BYPASS_BIT = 9;
	localparam int BCB_ARG_FORM_LSB = 12;
	localparam logic [1:0] BCB_FORM_EXPLICIT = 2'h0;
	localparam logic [1:0] BCB_FORM_INTEGER = 2'h1;
	localparam logic [1:0] BCB_FORM_PRESET = 2'h2;
	localparam logic [1:0] BCB_PRESET_TWO_ENTRY = 2'h0;
	localparam logic [1:0] BCB_PRESET_NO_QUEUE = 2'h1;
	localparam logic [1:0] BCB_PRESET_VALID_BYPASS = 2'h2;
	localparam logic [1:0] BCB_PRESET_READY_BYPASS = 2'h3;

	// ---------------------------------------------------------------
	// channel config: {ready_bypass, valid_bypass, depth}
	// ---------------------------------------------------------------
	typedef logic [6:0] bcb_cfg_t;
	localparam bcb_cfg_t BCB_CFG_TWO_ENTRY = 7'h02;
	localparam bcb_cfg_t BCB_CFG_NO_QUEUE = 7'h00;
	localparam bcb_cfg_t BCB_CFG_VALID_BYPASS = 7'h21;
	localparam bcb_cfg_t BCB_CFG_READY_BYPASS = 7'h41;
	localparam logic [4:0] BCB_DEPTH_MAX = 5'h10;

	typedef enum logic [1:0] {BCB_LINK_AXI, BCB_LINK_TL_UNCACHED, BCB_LINK_TL_COHERENT} bcb_link_t;

	// reset values and response codes
	localparam logic [1:0] BCB_LINK_MODE_RST = 2'h0;
	localparam logic [2:0] BCB_ARG_COUNT_RST = 3'h0;
	localparam logic [31:0] BCB_ARG_RST = 32'h0000_0000;
	localparam logic [1:0] BCB_RESP_OKAY = 2'h0;
	localparam logic [1:0] BCB_RESP_SLVERR = 2'h2;

	// turn one argument word into an effective channel config
	function automatic bcb_cfg_t bcb_decode_arg(input logic [31:0] arg);
		logic [4:0] d;
		logic [1:0] form;
		d = arg[BCB_ARG_DEPTH_LSB +: 5];
		form = arg[BCB_ARG_FORM_LSB +: 2];
		if (d > BCB_DEPTH_MAX)
			d = BCB_DEPTH_MAX;
		if (form == BCB_FORM_PRESET)
		begin
			case (arg[1:0])
				BCB_PRESET_NO_QUEUE: bcb_decode_arg = BCB_CFG_NO_QUEUE;
				BCB_PRESET_VALID_BYPASS: bcb_decode_arg = BCB_CFG_VALID_BYPASS;
				BCB_PRESET_READY_BYPASS: bcb_decode_arg = BCB_CFG_READY_BYPASS;
				default: bcb_decode_arg = BCB_CFG_TWO_ENTRY;
			endcase
		end
		else if (form == BCB_FORM_INTEGER)
			bcb_decode_arg = {2'b00, d};
		else
			bcb_decode_arg = {arg[BCB_ARG_READY_BYPASS_BIT], arg[BCB_ARG_VALID_BYPASS_BIT], d};
	endfunction

endpackage
`default_nettype wire

// *** rtl/bcb_queue_mem.sv ***
// storage array of one channel queue, read data out of a register
`timescale 1ns/1ps
`default_nettype none
module bcb_queue_mem #(
	parameter int W = 32,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// clock
	input wire logic clk,
	// write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// read side
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	// write-through on a same-address collision so a freshly stored head shows next cycle
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
	end
endmodule
`default_nettype wire

// *** rtl/bcb_chan_queue.sv ***
// one channel queue with run-time depth and valid/ready bypass options
`timescale 1ns/1ps
`default_nettype none
module bcb_chan_queue
	import bcb_pkg::*;
#(
	parameter int W = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire logic [4:0] cfg_depth,
	input wire logic cfg_valid_bypass,
	input wire logic cfg_ready_bypass,
	// filling side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	// status
	output logic [4:0] level
);
	logic [3:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [W-1:0] head;
	wire bypass_all = (cfg_depth == 5'h00);
	wire empty = (cnt_reg == 5'h00);
	wire full = (cnt_reg >= cfg_depth);
	wire through = empty && cfg_valid_bypass && out_ready;
	wire push = !bypass_all && in_valid && in_ready && !through;
	wire pop = !bypass_all && out_valid && out_ready && !empty;

	// handshake: zero depth wires straight through, else queue with optional bypass paths
	assign out_valid = bypass_all ? in_valid : (!empty || (cfg_valid_bypass && in_valid));
	assign out_data = (bypass_all || empty) ? in_data : head;
	assign in_ready = bypass_all ? out_ready : (!full || (cfg_ready_bypass && out_ready));
	assign level = cnt_reg;

	// ring pointers, arrival order kept
	assign wptr_next = push ? wptr_reg + 4'h1 : wptr_reg;
	assign rptr_next = pop ? rptr_reg + 4'h1 : rptr_reg;
	assign cnt_next = (push && !pop) ? cnt_reg + 5'h01 : ((pop && !push) ? cnt_reg - 5'h01 : cnt_reg);

	// state registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wptr_reg <= 4'h0;
			rptr_reg <= 4'h0;
			cnt_reg <= 5'h00;
		end
		else
		begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage, read address looks one step ahead so head is ready from a flop
	bcb_queue_mem #(.W(W), .DEPTH(DEPTH), .AW(4)) u_mem (
		.clk(clk),
		.we(push),
		.waddr(wptr_reg),
		.wdata(in_data),
		.raddr(rptr_next),
		.rdata(head)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_ZERO_PASS: assert property (@(posedge clk) disable iff (rst)
		bypass_all |-> (out_valid == in_valid && in_ready == out_ready && out_data == in_data))
		else $error("zero-depth channel not passed through");
	AST_VALID_BYPASS: assert property (@(posedge clk) disable iff (rst)
		(!bypass_all && cfg_valid_bypass && empty && in_valid) |-> (out_valid && out_data == in_data))
		else $error("valid bypass did not present arriving item");
	AST_READY_BYPASS: assert property (@(posedge clk) disable iff (rst)
		(!bypass_all && cfg_ready_bypass && full && out_ready && in_valid) |-> in_ready ##1 (cnt_reg == $past(cnt_reg)))
		else $error("ready bypass did not sustain full rate");
	AST_FULL_STALL: assert property (@(posedge clk) disable iff (rst)
		(!bypass_all && !cfg_ready_bypass && full) |-> !in_ready)
		else $error("full queue accepted an item");
	AST_HOLD_OUT: assert property (@(posedge clk) disable iff (rst)
		(out_valid && !out_ready && !empty) |=> (out_valid && $stable(out_data)))
		else $error("presented item changed before taken");
endmodule
`default_nettype wire

// *** rtl/bcb_channel_buffer.sv ***
// top of the bus channel buffer: five channel queues and the AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module bcb_channel_buffer (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register bus, write address
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [bcb_pkg::BCB_AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	// register bus, write data
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	// register bus, write response
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	// register bus, read address
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [bcb_pkg::BCB_AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	// register bus, read data
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	// channel filling side, one bit or word per channel
	input wire logic [bcb_pkg::BCB_NCH-1:0] CH_IN_VALID,
	input wire logic [bcb_pkg::BCB_NCH*bcb_pkg::BCB_DW-1:0] CH_IN_DATA,
	output logic [bcb_pkg::BCB_NCH-1:0] CH_IN_READY,
	// channel draining side
	output logic [bcb_pkg::BCB_NCH-1:0] CH_OUT_VALID,
	output logic [bcb_pkg::BCB_NCH*bcb_pkg::BCB_DW-1:0] CH_OUT_DATA,
	input wire logic [bcb_pkg::BCB_NCH-1:0] CH_OUT_READY
);
	import bcb_pkg::*;

	// ---------------------------------------------------------------
	// software-visible state
	// ---------------------------------------------------------------
	logic [1:0] link_mode_reg;
	logic [2:0] arg_count_reg;
	logic [31:0] arg_reg [BCB_NCH];
	bcb_cfg_t cfg_reg [BCB_NCH];
	bcb_cfg_t cfg_next [BCB_NCH];
	bcb_cfg_t arg_cfg [BCB_NCH];
	logic [4:0] level [BCB_NCH];
	logic [BCB_NCH-1:0] ch_idle;

	// ---------------------------------------------------------------
	// bus handshake state
	// ---------------------------------------------------------------
	logic aw_full_reg, aw_full_next;
	logic w_full_reg, w_full_next;
	logic [BCB_AXI_AW-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg, wready_reg, bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg;
	logic arready_reg, rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// merge byte lanes of a write into an old word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = new_w[8*b +: 8];
		merge_bytes = r;
	endfunction

	// which argument feeds a channel: 0..4, or 7 for the two-entry preset
	function automatic logic [2:0] arg_for_chan(input logic [1:0] mode, input logic [2:0] n,
		input logic [2:0] ch);
		logic towards_client;
		towards_client = (mode == BCB_LINK_AXI) ? (ch == 3'h2 || ch == 3'h4)
			: (ch == 3'h1 || ch == 3'h3);
		if (n == 3'h1)
			arg_for_chan = 3'h0;
		else if (n == 3'h2)
			arg_for_chan = towards_client ? 3'h1 : 3'h0;
		else if (n == 3'h5)
			arg_for_chan = ch;
		else
			arg_for_chan = 3'h7;
	endfunction

	// ---------------------------------------------------------------
	// channel configuration
	// ---------------------------------------------------------------
	wire all_idle = &ch_idle;
	wire cfg_upd = all_idle;

	// per-channel decode; uncached links carry no B, C or E traffic
	genvar gc;
	generate
		for (gc = 0; gc < BCB_NCH; gc++)
		begin : g_cfg
			wire [2:0] sel = arg_for_chan(link_mode_reg, arg_count_reg, 3'(gc));
			wire unused_chan = (link_mode_reg == BCB_LINK_TL_UNCACHED) && (gc != 0) && (gc != 3);
			assign arg_cfg[gc] = bcb_decode_arg(arg_reg[gc]);
			assign cfg_next[gc] = unused_chan ? BCB_CFG_NO_QUEUE
				: (sel == 3'h7) ? BCB_CFG_TWO_ENTRY
				: arg_cfg[sel];
			assign ch_idle[gc] = (level[gc] == 5'h00);
		end
	endgenerate

	// new configuration only lands while every queue is empty, so no item is stranded
	always_ff @(posedge CLK)
	begin
		for (int c = 0; c < BCB_NCH; c++)
			if (RST)
				cfg_reg[c] <= BCB_CFG_TWO_ENTRY;
			else if (cfg_upd)
				cfg_reg[c] <= cfg_next[c];
	end

	// ---------------------------------------------------------------
	// channel queues
	// ---------------------------------------------------------------
	generate
		for (gc = 0; gc < BCB_NCH; gc++)
		begin : g_q
			bcb_chan_queue #(.W(BCB_DW), .DEPTH(BCB_QDEPTH)) u_q (
				.clk(CLK),
				.rst(RST),
				.cfg_depth(cfg_reg[gc][4:0]),
				.cfg_valid_bypass(cfg_reg[gc][5]),
				.cfg_ready_bypass(cfg_reg[gc][6]),
				.in_valid(CH_IN_VALID[gc]),
				.in_data(CH_IN_DATA[gc*BCB_DW +: BCB_DW]),
				.in_ready(CH_IN_READY[gc]),
				.out_valid(CH_OUT_VALID[gc]),
				.out_data(CH_OUT_DATA[gc*BCB_DW +: BCB_DW]),
				.out_ready(CH_OUT_READY[gc]),
				.level(level[gc])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// write path
	// ---------------------------------------------------------------
	wire aw_take = S_AXI_AWVALID && awready_reg;
	wire w_take = S_AXI_WVALID && wready_reg;
	wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
	wire wr_arg = (aw_addr_reg >= BCB_OFS_ARG0) && (aw_addr_reg <= BCB_OFS_ARG4)
		&& (aw_addr_reg[1:0] == 2'h0);
	wire [2:0] wr_idx = 3'((aw_addr_reg - BCB_OFS_ARG0) >> 2);
	wire wr_mode = (aw_addr_reg == BCB_OFS_LINK_MODE);
	wire wr_count = (aw_addr_reg == BCB_OFS_ARG_COUNT);
	wire wr_ro = (aw_addr_reg == BCB_OFS_OCCUPANCY) || (aw_addr_reg == BCB_OFS_EFF_DEPTH);
	wire wr_hit = wr_arg || wr_mode || wr_count || wr_ro;
	wire [31:0] mode_merged = merge_bytes({30'h0, link_mode_reg}, w_data_reg, w_strb_reg);
	wire [31:0] count_merged = merge_bytes({29'h0, arg_count_reg}, w_data_reg, w_strb_reg);

	// address and data may come in either order; each slot frees once the write is done
	assign aw_full_next = (aw_full_reg || aw_take) && !do_write;
	assign w_full_next = (w_full_reg || w_take) && !do_write;
	assign bvalid_next = do_write || (bvalid_reg && !S_AXI_BREADY);

	// bus handshake flops
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= BCB_RESP_OKAY;
		end
		else
		begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= !aw_full_next;
			wready_reg <= !w_full_next;
			bvalid_reg <= bvalid_next;
			if (do_write)
				bresp_reg <= wr_hit ? BCB_RESP_OKAY : BCB_RESP_SLVERR;
		end
	end

	// payload capture
	always_ff @(posedge CLK)
	begin
		if (aw_take)
			aw_addr_reg <= S_AXI_AWADDR;
		if (w_take)
		begin
			w_data_reg <= S_AXI_WDATA;
			w_strb_reg <= S_AXI_WSTRB;
		end
	end

	// register writes; read-only registers silently keep their value
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			link_mode_reg <= BCB_LINK_MODE_RST;
			arg_count_reg <= BCB_ARG_COUNT_RST;
			for (int c = 0; c < BCB_NCH; c++)
				arg_reg[c] <= BCB_ARG_RST;
		end
		else if (do_write)
		begin
			if (wr_mode)
				link_mode_reg <= mode_merged[1:0];
			if (wr_count)
				arg_count_reg <= count_merged[2:0];
			if (wr_arg)
				arg_reg[wr_idx] <= merge_bytes(arg_reg[wr_idx], w_data_reg, w_strb_reg);
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	wire ar_take = S_AXI_ARVALID && arready_reg;
	wire rd_arg = (S_AXI_ARADDR >= BCB_OFS_ARG0) && (S_AXI_ARADDR <= BCB_OFS_ARG4)
		&& (S_AXI_ARADDR[1:0] == 2'h0);
	wire [2:0] rd_idx = 3'((S_AXI_ARADDR - BCB_OFS_ARG0) >> 2);
	wire [31:0] occupancy_word = {7'h00, level[4], level[3], level[2], level[1], level[0]};
	wire [31:0] eff_depth_word = {7'h00, cfg_reg[4][4:0], cfg_reg[3][4:0], cfg_reg[2][4:0],
		cfg_reg[1][4:0], cfg_reg[0][4:0]};
	logic [31:0] rd_word;
	logic rd_hit;

	// read decode
	always_comb
	begin
		rd_hit = 1'b1;
		if (S_AXI_ARADDR == BCB_OFS_LINK_MODE)
			rd_word = {30'h0, link_mode_reg};
		else if (S_AXI_ARADDR == BCB_OFS_ARG_COUNT)
			rd_word = {29'h0, arg_count_reg};
		else if (rd_arg)
			rd_word = arg_reg[rd_idx];
		else if (S_AXI_ARADDR == BCB_OFS_OCCUPANCY)
			rd_word = occupancy_word;
		else if (S_AXI_ARADDR == BCB_OFS_EFF_DEPTH)
			rd_word = eff_depth_word;
		else
		begin
			rd_word = 32'h0000_0000;
			rd_hit = 1'b0;
		end
	end

	assign rvalid_next = ar_take || (rvalid_reg && !S_AXI_RREADY);

	// one read outstanding; address is refused while an answer waits
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= BCB_RESP_OKAY;
		end
		else
		begin
			arready_reg <= !rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_take)
			begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_hit ? BCB_RESP_OKAY : BCB_RESP_SLVERR;
			end
		end
	end

	// bus outputs straight from flops
	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence seq_both_taken;
		aw_full_reg && w_full_reg && !bvalid_reg;
	endsequence
	sequence seq_resp_out;
		##1 S_AXI_BVALID;
	endsequence

	AST_WRITE_RESP: assert property (@(posedge CLK) disable iff (RST)
		seq_both_taken |-> seq_resp_out)
		else $error("write response missing one cycle after both halves");
	AST_CFG_DEFAULT: assert property (@(posedge CLK) disable iff (RST)
		(cfg_upd && arg_count_reg == 3'h0 && link_mode_reg != BCB_LINK_TL_UNCACHED)
		|=> (cfg_reg[0] == 7'h02 && cfg_reg[2] == 7'h02 && cfg_reg[4] == 7'h02))
		else $error("default preset not applied");
	AST_CFG_SINGLE: assert property (@(posedge CLK) disable iff (RST)
		(cfg_upd && arg_count_reg == 3'h1 && link_mode_reg == BCB_LINK_AXI)
		|=> (cfg_reg[1] == cfg_reg[0] && cfg_reg[4] == cfg_reg[0]))
		else $error("single argument not shared by all channels");
	AST_TL_PAIR: assert property (@(posedge CLK) disable iff (RST)
		(cfg_upd && arg_count_reg == 3'h2 && link_mode_reg == BCB_LINK_TL_COHERENT)
		|=> (cfg_reg[2] == $past(arg_cfg[0]) && cfg_reg[3] == $past(arg_cfg[1])))
		else $error("coherent two-argument split wrong");
	AST_AXI_PAIR: assert property (@(posedge CLK) disable iff (RST)
		(cfg_upd && arg_count_reg == 3'h2 && link_mode_reg == BCB_LINK_AXI)
		|=> (cfg_reg[3] == $past(arg_cfg[0]) && cfg_reg[2] == $past(arg_cfg[1])))
		else $error("axi two-argument split wrong");
	AST_FIVE_ARGS: assert property (@(posedge CLK) disable iff (RST)
		(cfg_upd && arg_count_reg == 3'h5 && link_mode_reg != BCB_LINK_TL_UNCACHED)
		|=> (cfg_reg[1] == $past(arg_cfg[1]) && cfg_reg[4] == $past(arg_cfg[4])))
		else $error("five-argument order wrong");
	AST_UNCACHED: assert property (@(posedge CLK) disable iff (RST)
		(cfg_upd && link_mode_reg == BCB_LINK_TL_UNCACHED)
		|=> (cfg_reg[1] == 7'h00 && cfg_reg[2] == 7'h00 && cfg_reg[4] == 7'h00))
		else $error("uncached link left a queue on an absent channel");
	AST_INT_FORM: assert property (@(posedge CLK) disable iff (RST)
		(cfg_upd && arg_count_reg == 3'h1 && arg_reg[0][13:12] == 2'h1)
		|=> (cfg_reg[0][6:5] == 2'b00))
		else $error("integer argument left a bypass on");
endmodule
`default_nettype wire

// *** sim/bcb_sink_model.sv ***
// far-side manager model: takes channel items with chosen back-pressure
`timescale 1ns/1ps
`default_nettype none
module bcb_sink_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// 0 always ready, 1 stalled, 2 random stalls
	input wire logic [1:0] mode,
	// draining side of the buffer
	output logic [bcb_pkg::BCB_NCH-1:0] ready
);
	import bcb_pkg::*;
	int seed = 32'hBF81A71E;
	// ready only moves just after an edge, so a taken item is never half-seen
	always @(posedge clk)
		ready <= (rst || mode == 2'h1) ? '0 : (mode == 2'h0) ? '1 : BCB_NCH'($random(seed));
endmodule
`default_nettype wire

// *** sim/bcb_channel_buffer_tb_top.sv ***
// self-checking bench of the bus channel buffer
`timescale 1ns/1ps
`default_nettype none
module bcb_channel_buffer_tb_top;
	import bcb_pkg::*;
	logic CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
	logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, drv_on = 0, drv_full = 0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [7:0] S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0;
	logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp, pmode = 2'h0;
	logic [4:0] CH_IN_VALID = 5'h0, CH_IN_READY, CH_OUT_VALID, CH_OUT_READY;
	logic [159:0] CH_IN_DATA = 160'h0, CH_OUT_DATA;
	logic [31:0] expq[5][$];
	logic [6:0] ec[5];
	logic [31:0] ew;
	int err_total = 0, cmp_count = 0, seed = 32'hBF81A71E;
	// link mode, argument count and arguments of each configuration case
	int cm[7] = '{0, 2, 0, 0, 2, 2, 1};
	int cn[7] = '{0, 1, 2, 5, 2, 5, 1};
	logic [15:0] ca[7][5] = '{'{16'h1005, 16'h1005, 16'h1005, 16'h1005, 16'h1005},
		'{16'h1108, 16'h0, 16'h0, 16'h0, 16'h0}, '{16'h2000, 16'h2003, 16'h0, 16'h0, 16'h0},
		'{16'h1001, 16'h1002, 16'h1001, 16'h1001, 16'h1002},
		'{16'h2002, 16'h2001, 16'h0, 16'h0, 16'h0},
		'{16'h0003, 16'h0104, 16'h0205, 16'h0006, 16'h0310},
		'{16'h1003, 16'h0, 16'h0, 16'h0, 16'h0}};

	bcb_channel_buffer i_dut (.CLK(CLK), .RST(RST),
		.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWPROT(S_AXI_AWPROT),
		.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARPROT(S_AXI_ARPROT),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.CH_IN_VALID(CH_IN_VALID), .CH_IN_DATA(CH_IN_DATA), .CH_IN_READY(CH_IN_READY),
		.CH_OUT_VALID(CH_OUT_VALID), .CH_OUT_DATA(CH_OUT_DATA), .CH_OUT_READY(CH_OUT_READY));
	bcb_sink_model i_sink (.clk(CLK), .rst(RST), .mode(pmode), .ready(CH_OUT_READY));

	always #2 CLK = ~CLK;

	// ---------------------------------------------------------------
	// checking and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic conclude;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic b = 0;
		@(posedge CLK);
		S_AXI_AWVALID <= 1;
		S_AXI_AWADDR <= a;
		S_AXI_WVALID <= 1;
		S_AXI_WDATA <= d;
		S_AXI_BREADY <= 1;
		while (!b)
		begin
			@(posedge CLK);
			if (S_AXI_AWREADY)
				S_AXI_AWVALID <= 0;
			if (S_AXI_WREADY)
				S_AXI_WVALID <= 0;
			b = S_AXI_BVALID;
		end
		S_AXI_BREADY <= 0;
		chk("bresp", 32'(S_AXI_BRESP), 32'h0);
	endtask

	task automatic rdr(input logic [7:0] a);
		logic b = 0;
		@(posedge CLK);
		S_AXI_ARVALID <= 1;
		S_AXI_ARADDR <= a;
		S_AXI_RREADY <= 1;
		while (!b)
		begin
			@(posedge CLK);
			if (S_AXI_ARREADY)
				S_AXI_ARVALID <= 0;
			b = S_AXI_RVALID;
		end
		S_AXI_RREADY <= 0;
		rd = S_AXI_RDATA;
		rsp = S_AXI_RRESP;
	endtask

	// expected {ready bypass, valid bypass, depth} of channel c
	function automatic logic [6:0] ecfg(input int m, input int n, input int c,
		input logic [15:0] a[5]);
		logic [15:0] w;
		w = (n == 1) ? a[0] : (n == 5) ? a[c] : (n != 2) ? 16'h2000 :
			(((m == 0 ? 5'h0B : 5'h15) >> c) & 5'h1) ? a[0] : a[1];
		if (m == 1 && (c == 1 || c == 2 || c == 4))
			return 7'h00;
		if (w[13:12] == 2'h2)
			return w[1:0] == 2'h1 ? 7'h00 : w[1:0] == 2'h2 ? 7'h21 : w[1:0] == 2'h3 ? 7'h41 : 7'h02;
		if (w[13:12] == 2'h1)
			return {2'h0, w[4:0]};
		return {w[9:8], w[4:0]};
	endfunction

	// ---------------------------------------------------------------
	// client driver, scoreboard and sequence
	// ---------------------------------------------------------------
	// a new item only once the held one was taken
	always @(posedge CLK)
		for (int c = 0; c < 5; c++)
			if (!CH_IN_VALID[c] || CH_IN_READY[c])
			begin
				CH_IN_VALID[c] <= drv_on && (drv_full || $random(seed) % 2);
				CH_IN_DATA[c*32+:32] <= $random(seed);
			end

	// depth-zero items are pushed before popped in the same edge
	always @(posedge CLK)
		for (int c = 0; c < 5; c++)
		begin
			if (CH_IN_VALID[c] && CH_IN_READY[c])
				expq[c].push_back(CH_IN_DATA[c*32+:32]);
			if (CH_OUT_VALID[c] && CH_OUT_READY[c])
				chk("ch_out", CH_OUT_DATA[c*32+:32], expq[c].size() ? expq[c].pop_front() : 32'hX);
		end

	initial
	begin
		repeat (3) @(posedge CLK);
		RST <= 0;
		rdr(8'h40);
		chk("unmapped", 32'(rsp), 32'h2);
		rdr(BCB_OFS_ARG0);
		chk("arg0_rst", rd, 32'h0);
		// only the low byte lane may land
		S_AXI_WSTRB <= 4'h1;
		wr(BCB_OFS_ARG0, 32'hFFFF_FFFF);
		S_AXI_WSTRB <= 4'hF;
		rdr(BCB_OFS_ARG0);
		chk("strobe", rd, 32'h0000_00FF);
		for (int k = 0; k < 7; k++)
		begin
			wr(BCB_OFS_LINK_MODE, 32'(cm[k]));
			wr(BCB_OFS_ARG_COUNT, 32'(cn[k]));
			for (int j = 0; j < 5; j++)
				wr(BCB_OFS_ARG0 + 8'(4 * j), 32'(ca[k][j]));
			for (int j = 0; j < 5; j++)
				ec[j] = ecfg(cm[k], cn[k], j, ca[k]);
			ew = {7'h0, ec[4][4:0], ec[3][4:0], ec[2][4:0], ec[1][4:0], ec[0][4:0]};
			rdr(BCB_OFS_EFF_DEPTH);
			chk("eff_depth", rd, ew);
			// far side stalled: fill every queue until it refuses
			pmode <= 2'h1;
			drv_full <= 1;
			drv_on <= 1;
			@(posedge CLK);
			#1;
			for (int j = 0; j < 5; j++)
				chk("out_valid", 32'(CH_OUT_VALID[j]), 32'(ec[j][5] || !ec[j][4:0]));
			repeat (20) @(posedge CLK);
			drv_on <= 0;
			#1;
			for (int j = 0; j < 5; j++)
				chk("fill", 32'(expq[j].size()), 32'(ec[j][4:0]));
			// every queue stands full, so occupancy equals the effective depths
			rdr(BCB_OFS_OCCUPANCY);
			chk("occupancy", rd, ew);
			pmode <= 2'h0;
			@(posedge CLK);
			#1;
			for (int j = 0; j < 5; j++)
				chk("full_ready", 32'(CH_IN_READY[j]), 32'(ec[j][6] || !ec[j][4:0]));
			// random traffic against random stalls, then drain
			pmode <= 2'h2;
			drv_full <= 0;
			drv_on <= 1;
			repeat (150) @(posedge CLK);
			drv_on <= 0;
			pmode <= 2'h0;
			repeat (40) @(posedge CLK);
			for (int j = 0; j < 5; j++)
				chk("drained", 32'(expq[j].size()), 32'h0);
		end
		conclude();
	end

	// cut a hang well past the under two thousand cycles the run needs
	initial
	begin
		#40000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
